/* rtl/icfm_top.sv */
module icfm_top #(
    parameter int NUM_IN = icfm_pkg::NUM_IN,
    parameter int PER_W  = icfm_pkg::PER_W
) (
    input  wire logic                        ref_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic [NUM_IN-1:0]           clk_in_i,
    input  wire logic                        reference_crystal_input_i,
    input  wire logic [NUM_IN-1:0]           in_en_wr_i,
    input  wire logic [NUM_IN-1:0]           in_en_val_i,
    input  wire logic [NUM_IN-1:0]           los_mon_en_i,
    input  wire icfm_pkg::icfm_los_cfg_t     los_cfg_i [NUM_IN],
    input  wire icfm_pkg::icfm_los_cfg_t     ref_los_cfg_i,
    input  wire logic [PER_W-1:0]            ofs_tol_i,
    input  wire logic [1:0]                  sel_i,
    input  wire logic                        fastlock_en_i,
    input  wire logic                        lol_on_switch_i,
    input  wire logic                        ref_los_out_dis_i,
    input  wire logic [NUM_IN-1:0]           sticky_clr_i,
    input  wire logic                        ref_sticky_clr_i,
    output logic [NUM_IN-1:0]                in_en_o,
    output icfm_pkg::icfm_status_t           status_o,
    output logic [NUM_IN-1:0]                signal_lost_sticky_o,
    output logic                             reference_signal_lost_sticky_o,
    output logic [1:0]                       active_sel_o,
    output logic                             fast_acq_o,
    output logic                             out_clk_en_o,
    output logic                             out_clk_o
);
    localparam int N = NUM_IN + 1;

    // config structs and enable resets are sized by the package
    if (NUM_IN != icfm_pkg::NUM_IN || PER_W != icfm_pkg::PER_W) begin : g_bad_param
        $error("icfm_top: NUM_IN and PER_W must match the package");
    end

    // two-flop sync of all clock pins
    logic [N-1:0]       s1_ff, s2_ff, s3_ff;
    logic [N-1:0]       raw_pins;
    assign raw_pins = {reference_crystal_input_i, clk_in_i};

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= raw_pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    logic [N-1:0] rise;
    assign rise = s2_ff & ~s3_ff;

    // input buffer enables
    logic [NUM_IN-1:0] in_en_ff;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_en_ff <= icfm_pkg::IN_EN_RST;
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (in_en_wr_i[i]) in_en_ff[i] <= in_en_val_i[i];
            end
        end
    end
    assign in_en_o = in_en_ff;

    // per-monitor configuration, reference last
    icfm_pkg::icfm_los_cfg_t cfg [N];
    logic [N-1:0]            mon_act;
    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            cfg[i]     = los_cfg_i[i];
            mon_act[i] = in_en_ff[i] & los_mon_en_i[i];
        end
        cfg[NUM_IN]     = ref_los_cfg_i;
        mon_act[NUM_IN] = 1'b1;
    end

    // period measurement and loss detection
    logic [PER_W-1:0]          per_cnt_ff   [N];
    logic [PER_W-1:0]          last_per_ff  [N];
    logic [icfm_pkg::MISS_W-1:0] miss_cnt_ff [N];
    logic [N-1:0]              live_ff;

    function automatic logic [PER_W-1:0] sat_inc(input logic [PER_W-1:0] v);
        sat_inc = (&v) ? v : PER_W'(v + 1'b1);
    endfunction : sat_inc

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N; i++) begin
                per_cnt_ff[i]  <= '0;
                last_per_ff[i] <= '0;
                miss_cnt_ff[i] <= '0;
            end
            live_ff <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (!mon_act[i]) begin
                    per_cnt_ff[i]  <= '0;
                    miss_cnt_ff[i] <= '0;
                    live_ff[i]     <= 1'b0;
                end else if (rise[i]) begin
                    per_cnt_ff[i]  <= '0;
                    last_per_ff[i] <= per_cnt_ff[i];
                    if (per_cnt_ff[i] < cfg[i].min_period) begin
                        if (miss_cnt_ff[i] >= cfg[i].miss_limit)
                            live_ff[i] <= 1'b1;
                        else
                            miss_cnt_ff[i] <= miss_cnt_ff[i] + 1'b1;
                    end else begin
                        miss_cnt_ff[i] <= '0;
                        live_ff[i]     <= 1'b0;
                    end
                end else if (per_cnt_ff[i] >= cfg[i].max_period) begin
                    // restart so a stalled input keeps counting misses
                    per_cnt_ff[i] <= '0;
                    if (miss_cnt_ff[i] >= cfg[i].miss_limit)
                        live_ff[i] <= 1'b1;
                    else
                        miss_cnt_ff[i] <= miss_cnt_ff[i] + 1'b1;
                end else begin
                    per_cnt_ff[i] <= sat_inc(per_cnt_ff[i]);
                end
            end
        end
    end

    // sticky flags, set wins over clear
    logic [N-1:0] sticky_ff;
    logic [N-1:0] clr;
    assign clr = {ref_sticky_clr_i, sticky_clr_i};
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sticky_ff <= '0;
        end else begin
            sticky_ff <= (sticky_ff & ~clr) | live_ff;
        end
    end
    assign signal_lost_sticky_o           = sticky_ff[NUM_IN-1:0];
    assign reference_signal_lost_sticky_o = sticky_ff[NUM_IN];

    // frequency offset vs reference period
    logic [NUM_IN-1:0] oof_ff;
    function automatic logic [PER_W-1:0] absdiff(input logic [PER_W-1:0] a,
                                                 input logic [PER_W-1:0] b);
        absdiff = (a > b) ? PER_W'(a - b) : PER_W'(b - a);
    endfunction : absdiff

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oof_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (!mon_act[i])
                    oof_ff[i] <= 1'b0;
                else if (rise[i])
                    oof_ff[i] <= absdiff(last_per_ff[i],
                                         last_per_ff[NUM_IN]) > ofs_tol_i;
            end
        end
    end

    // input switch sequencing
    icfm_pkg::icfm_sw_state_t sw_ff;
    logic [1:0]               sel_ff;
    logic                     fast_ff;
    logic                     lol_ff;
    logic                     out_ff;
    logic [PER_W-1:0]         half_ff;
    logic                     sel_ok;
    assign sel_ok = ~live_ff[sel_ff] & ~oof_ff[sel_ff];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_ff   <= icfm_pkg::SW_RUN;
            sel_ff  <= '0;
            fast_ff <= 1'b0;
        end else begin
            unique case (sw_ff)
                icfm_pkg::SW_RUN: begin
                    if (sel_i != sel_ff && !live_ff[sel_i])
                        sw_ff <= icfm_pkg::SW_HOLD;
                end
                icfm_pkg::SW_HOLD: begin
                    if (!out_ff) begin
                        sel_ff  <= sel_i;
                        fast_ff <= fastlock_en_i;
                        sw_ff   <= icfm_pkg::SW_WAIT;
                    end
                end
                icfm_pkg::SW_WAIT: begin
                    if (rise[sel_ff] && sel_ok) begin
                        fast_ff <= 1'b0;
                        sw_ff   <= icfm_pkg::SW_RUN;
                    end
                end
                default: sw_ff <= icfm_pkg::SW_RUN;
            endcase
        end
    end

    // lock-lost indicator
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lol_ff <= 1'b1;
        end else begin
            lol_ff <= live_ff[sel_ff] | oof_ff[sel_ff] | live_ff[NUM_IN]
                    | (lol_on_switch_i && sw_ff == icfm_pkg::SW_WAIT);
        end
    end

    // output clock: whole half periods only, held low while switching
    logic out_dis;
    assign out_dis = (live_ff[NUM_IN] & ~ref_los_out_dis_i)
                   | (sw_ff != icfm_pkg::SW_RUN);
    // no rising edge until a usable half period is known
    logic [PER_W-1:0] half_per;
    assign half_per = last_per_ff[sel_ff] >> 1;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_ff  <= 1'b0;
            half_ff <= '0;
        end else begin
            if (rise[sel_ff]) begin
                half_ff <= half_per;
            end
            if (half_ff == '0 || (out_dis && !out_ff)) begin
                half_ff <= half_per;
                if (out_dis || (!out_ff && half_per == '0))
                    out_ff <= 1'b0;
                else
                    out_ff <= ~out_ff;
            end else if (!rise[sel_ff]) begin
                half_ff <= half_ff - 1'b1;
            end
        end
    end

    logic out_en_ff;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) out_en_ff <= 1'b0;
        else          out_en_ff <= ~out_dis;
    end

    assign status_o.signal_lost           = live_ff[NUM_IN-1:0];
    assign status_o.freq_offset_fault     = oof_ff;
    assign status_o.reference_signal_lost = live_ff[NUM_IN];
    assign status_o.lock_lost             = lol_ff;
    assign active_sel_o                   = sel_ff;
    assign fast_acq_o                     = fast_ff;
    assign out_clk_en_o                   = out_en_ff;
    assign out_clk_o                      = out_ff;
endmodule : icfm_top

/* rtl/icfm_pkg.sv */
package icfm_pkg;
    localparam int          NUM_IN         = 4;
    localparam int          PER_W          = 16;
    localparam int          MISS_W         = 4;
    localparam int          DIV_W          = 8;
    localparam logic [3:0]  IN_EN_RST      = 4'hF;
    localparam logic [15:0] MAX_PER_RST    = 16'h0100;
    localparam logic [15:0] MIN_PER_RST    = 16'h0002;
    localparam logic [3:0]  MISS_LIM_RST   = 4'h2;
    localparam logic [15:0] OFS_TOL_RST    = 16'h0004;
    localparam logic [7:0]  OUT_DIV_RST    = 8'h02;
    localparam int          PPM_TOL        = 20;

    typedef struct packed {
        logic [PER_W-1:0]  max_period;
        logic [PER_W-1:0]  min_period;
        logic [MISS_W-1:0] miss_limit;
    } icfm_los_cfg_t;

    typedef struct packed {
        logic [NUM_IN-1:0] signal_lost;
        logic [NUM_IN-1:0] freq_offset_fault;
        logic              reference_signal_lost;
        logic              lock_lost;
    } icfm_status_t;

    typedef enum logic [1:0] {
        SW_RUN  = 2'b00,
        SW_HOLD = 2'b01,
        SW_WAIT = 2'b11
    } icfm_sw_state_t;
endpackage : icfm_pkg

/* verification/icfm_clk_src.sv */
module icfm_clk_src #(
    parameter int HALF = 20
) (
    input  wire logic [4:0] run_i,
    output logic      [3:0] clk_o,
    output logic            ref_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ph = 1'b0;
    always #(HALF) ph = ~ph;
    // a stopped source parks low like a powered-off oscillator
    assign clk_o = {4{ph}} & run_i[3:0];
    assign ref_o = ph & run_i[4];
endmodule : icfm_clk_src

/* verification/icfm_checker_assertions.sv */
module icfm_checker #(
    parameter int NUM_IN = 4
) (
    input wire logic                   ref_clk_i,
    input wire logic                   rst_n_i,
    input wire logic [NUM_IN-1:0]      in_en_wr_i,
    input wire logic [NUM_IN-1:0]      in_en_val_i,
    input wire logic [NUM_IN-1:0]      los_mon_en_i,
    input wire logic [NUM_IN-1:0]      sticky_clr_i,
    input wire logic                   fastlock_en_i,
    input wire logic                   ref_los_out_dis_i,
    input wire logic [NUM_IN-1:0]      in_en_o,
    input wire icfm_pkg::icfm_status_t status_o,
    input wire logic [NUM_IN-1:0]      signal_lost_sticky_o,
    input wire logic                   reference_signal_lost_sticky_o,
    input wire logic                   fast_acq_o,
    input wire logic                   out_clk_en_o,
    input wire logic                   out_clk_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_en_write: assert property (
        1'b1 |=> in_en_o == ($past(in_en_o & ~in_en_wr_i) | $past(in_en_val_i & in_en_wr_i)))
        else $error("buffer enable write mismatch");
    a_live_masked: assert property (
        (status_o.signal_lost & ~(in_en_o & los_mon_en_i) & ~$past(in_en_o & los_mon_en_i)) == '0)
        else $error("live loss set on disabled input");
    a_sticky_set: assert property (
        (~signal_lost_sticky_o & $past(status_o.signal_lost)) == '0)
        else $error("sticky missed a live loss");
    a_sticky_hold: assert property (
        (~signal_lost_sticky_o & $past(signal_lost_sticky_o & ~sticky_clr_i)) == '0)
        else $error("sticky dropped without clear");
    a_sticky_clear: assert property (
        (signal_lost_sticky_o & $past(sticky_clr_i & ~status_o.signal_lost)) == '0)
        else $error("sticky survived a clear");
    a_sticky_cause: assert property (
        (signal_lost_sticky_o & ~$past(signal_lost_sticky_o | status_o.signal_lost)) == '0)
        else $error("sticky set without live loss");
    a_ref_sticky: assert property (
        status_o.reference_signal_lost |=> reference_signal_lost_sticky_o)
        else $error("reference sticky missed");
    a_ref_out_off: assert property (
        (status_o.reference_signal_lost && !ref_los_out_dis_i) [*2] |-> !out_clk_en_o)
        else $error("outputs on during reference loss");
    a_no_runt: assert property (
        $rose(out_clk_o) |=> out_clk_o)
        else $error("runt output pulse");
    a_fast_cause: assert property (
        $rose(fast_acq_o) |-> $past(fastlock_en_i))
        else $error("fast acquisition while disabled");
endmodule : icfm_checker

bind icfm_top icfm_checker #(.NUM_IN(NUM_IN)) i_chk (
    .ref_clk_i                      (ref_clk_i),
    .rst_n_i                        (rst_n_i),
    .in_en_wr_i                     (in_en_wr_i),
    .in_en_val_i                    (in_en_val_i),
    .los_mon_en_i                   (los_mon_en_i),
    .sticky_clr_i                   (sticky_clr_i),
    .fastlock_en_i                  (fastlock_en_i),
    .ref_los_out_dis_i              (ref_los_out_dis_i),
    .in_en_o                        (in_en_o),
    .status_o                       (status_o),
    .signal_lost_sticky_o           (signal_lost_sticky_o),
    .reference_signal_lost_sticky_o (reference_signal_lost_sticky_o),
    .fast_acq_o                     (fast_acq_o),
    .out_clk_en_o                   (out_clk_en_o),
    .out_clk_o                      (out_clk_o)
);

/* verification/input_clock_fault_monitor_bench.sv */
module input_clock_fault_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic [4:0]              run = 5'h1F;
    logic [3:0]              cin, en_wr, en_val, mon_en, s_clr, en, stk, seen;
    logic                    xtal, fast_en, lol_sw, o_dis, r_clr, r_stk, fa, oc_en, oc;
    logic [1:0]              sel, act;
    icfm_pkg::icfm_los_cfg_t cfg [4];
    icfm_pkg::icfm_status_t  st;
    int                      miscompares = 0;
    int                      n_tests = 0;
    always #2 clk = ~clk;
    icfm_clk_src i_src (.run_i(run), .clk_o(cin), .ref_o(xtal));
    icfm_top i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_in_i(cin),
        .reference_crystal_input_i(xtal), .in_en_wr_i(en_wr), .in_en_val_i(en_val),
        .los_mon_en_i(mon_en), .los_cfg_i(cfg), .ref_los_cfg_i(cfg[0]),
        .ofs_tol_i(16'h0004), .sel_i(sel), .fastlock_en_i(fast_en),
        .lol_on_switch_i(lol_sw), .ref_los_out_dis_i(o_dis), .sticky_clr_i(s_clr),
        .ref_sticky_clr_i(r_clr), .in_en_o(en), .status_o(st), .signal_lost_sticky_o(stk),
        .reference_signal_lost_sticky_o(r_stk), .active_sel_o(act), .fast_acq_o(fa),
        .out_clk_en_o(oc_en), .out_clk_o(oc));
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic give_verdict;
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end
    initial begin
        en_wr = 4'h0;
        en_val = 4'h0;
        mon_en = 4'hF;
        s_clr = 4'h0;
        r_clr = 1'b0;
        sel = 2'h0;
        fast_en = 1'b1;
        lol_sw = 1'b0;
        o_dis = 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg[i] = '{16'h0010, 16'h0002, 4'h2};
        end
        tick(6);
        rst_n = 1'b1;
        chk("in_en", 4'hF, en);
        tick(100);
        chk("live", 4'h0, st.signal_lost);
        chk("offset", 4'h0, st.freq_offset_fault);
        chk("out_on", 4'h1, 4'(oc_en));
        chk("lol_idle", 4'h0, 4'(st.lock_lost));
        run[1] = 1'b0;
        tick(30);
        chk("live_early", 4'h0, st.signal_lost);
        tick(60);
        chk("live_lost", 4'h2, st.signal_lost);
        chk("sticky", 4'h2, stk);
        s_clr = 4'h2;
        tick(1);
        s_clr = 4'h0;
        chk("clr_refused", 4'h2, stk);
        run[1] = 1'b1;
        tick(40);
        chk("live_back", 4'h0, st.signal_lost);
        chk("sticky_held", 4'h2, stk);
        s_clr = 4'h2;
        tick(1);
        s_clr = 4'h0;
        tick(1);
        chk("sticky_clr", 4'h0, stk);
        mon_en = 4'hB;
        en_wr = 4'h8;
        tick(1);
        en_wr = 4'h0;
        run[3:2] = 2'h0;
        tick(90);
        chk("in_en_off", 4'h7, en);
        chk("live_masked", 4'h0, st.signal_lost);
        run[3:2] = 2'h3;
        mon_en = 4'hF;
        en_wr = 4'h8;
        en_val = 4'h8;
        tick(1);
        en_wr = 4'h0;
        run[4] = 1'b0;
        tick(90);
        chk("ref_live", 4'h1, 4'(st.reference_signal_lost));
        chk("ref_sticky", 4'h1, 4'(r_stk));
        chk("out_off", 4'h0, 4'(oc_en));
        chk("lol_ref", 4'h1, 4'(st.lock_lost));
        o_dis = 1'b1;
        tick(10);
        chk("out_kept", 4'h1, 4'(oc_en));
        run[4] = 1'b1;
        o_dis = 1'b0;
        tick(60);
        r_clr = 1'b1;
        tick(1);
        r_clr = 1'b0;
        tick(1);
        chk("ref_clr", 4'h0, 4'(r_stk));
        lol_sw = 1'b1;
        sel = 2'h1;
        seen = 4'h0;
        repeat (60) begin
            tick(1);
            seen = seen | {1'b0, oc, fa, st.lock_lost};
        end
        chk("lol_switch", 4'h1, 4'(seen[0]));
        chk("fast_switch", 4'h1, 4'(seen[1]));
        chk("out_toggles", 4'h1, 4'(seen[2]));
        chk("fast_done", 4'h0, 4'(fa));
        chk("active", 4'h1, 4'(act));
        chk("out_sw", 4'h1, 4'(oc_en));
        run[2] = 1'b0;
        tick(90);
        sel = 2'h2;
        tick(60);
        chk("sw_refused", 4'h1, 4'(act));
        give_verdict();
    end
endmodule : input_clock_fault_monitor_bench
